// file: hdl/scs_device.sv
// How it works
// - Reset clears register 0; pins configure device.
// - Register 0 value 01h hands configuration to registers.
// - Strap resistor picks address 71h, 72h, 73h, 76h.
// - Master opens frames with the start condition.
// - Master closes frames with the stop condition.
// - Acknowledge own address, release line otherwise.
// - Acknowledge every written data byte.
// - Master acknowledges reads, not-acknowledges last, stops.
// - Frames open with start, close with stop.
// - Lines only pulled low or released.
// - Register 0 bit 7 picks frequency range.
// - Register 0 bit 6 stored and read back.
// - Register 0 bit 1 requests sleep, keeps registers.
// - Register control never moves the bus address.
// - Register 1 bit 7 picks address source.
// - Register 1 bits 6:0 hold the address.
// - Register 2 bit 7 enables link outputs.
// - Register 2 bit 3 picks output swing.
// - Register 2 bits 2:0 pick oscillator rate.
// - Power down returns registers to reset values.
// - Stream-stop sleep keeps register contents.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module scs_device (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  scs_bus_if.dev                            bus,
  input  wire logic                         power_down_n,
  input  wire scs_pkg::scs_strap_t          address_strap,
  input  wire logic                         pin_low_freq_range_sel,
  input  wire logic                         pin_output_sleep_state_sel,
  input  wire logic                         pin_link_output_drive_en,
  input  wire logic                         pin_swing_level_sel,
  output logic                              low_freq_range_sel,
  output logic                              output_sleep_state_sel,
  output logic                              sleep_mode,
  output logic                              link_output_drive_en,
  output logic                              swing_level_sel,
  output logic [scs_pkg::SCS_OSC_MSB:0]     internal_osc_freq_sel,
  output logic [scs_pkg::SCS_ADDR_W-1:0]    bus_address_setting
);
  import scs_pkg::*;

  logic [7:0]           regs_q [SCS_REG_COUNT];
  logic                 scl_q;
  logic                 sda_q;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  logic [6:0]           strap_addr_q;
  logic                 strap_done_q;
  logic [6:0]           own_addr;
  scs_dev_state_t       state_q;
  logic [3:0]           bitcnt_q;
  logic [7:0]           rx_q;
  logic [7:0]           tx_q;
  logic [7:0]           ptr_q;
  logic                 rw_q;
  logic                 mack_q;
  logic                 sda_oe_q;
  logic [7:0]           rd_cur;
  logic                 wr_en;
  logic                 reg_ctrl;

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign scl_rise  = bus.scl & ~scl_q;
  assign scl_fall  = ~bus.scl & scl_q;
  assign start_det = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_det  = scl_q & bus.scl & ~sda_q & bus.sda;

  // The strap is caught once, in the first cycle after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_addr_q <= SCS_ADDR_OPEN;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      case (address_strap)
        SCS_STRAP_R0470: strap_addr_q <= SCS_ADDR_R0470;
        SCS_STRAP_R2700: strap_addr_q <= SCS_ADDR_R2700;
        SCS_STRAP_R8200: strap_addr_q <= SCS_ADDR_R8200;
        default:         strap_addr_q <= SCS_ADDR_OPEN;
      endcase
    end
  end

  // The address source ignores the register-control bit on purpose.
  assign own_addr = regs_q[1][SCS_ADDR_SRC_BIT] ? regs_q[1][6:0] : strap_addr_q;

  always_comb begin
    rd_cur = 8'h00;
    if (ptr_q < 8'(SCS_REG_COUNT)) begin
      rd_cur = regs_q[ptr_q[1:0]];
    end
  end

  // Protocol engine: bits are counted on SCL rises, the line is steered on falls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= SCS_DS_IDLE;
      bitcnt_q <= 4'h0;
      rx_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (!power_down_n) begin
      state_q  <= SCS_DS_IDLE;
      bitcnt_q <= 4'h0;
      ptr_q    <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q  <= SCS_DS_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q  <= SCS_DS_IDLE;
      sda_oe_q <= 1'b0;
    end else if (state_q != SCS_DS_IDLE) begin
      if (scl_rise) begin
        if (bitcnt_q < 4'h8) begin
          rx_q <= {rx_q[6:0], bus.sda};
        end else begin
          mack_q <= ~bus.sda;
        end
        bitcnt_q <= bitcnt_q + 4'h1;
      end else if (scl_fall) begin
        if (bitcnt_q == 4'h8) begin
          sda_oe_q <= 1'b0;
          case (state_q)
            SCS_DS_ADDR: begin
              if (rx_q[7:1] == own_addr) begin
                sda_oe_q <= 1'b1;
                rw_q     <= rx_q[0];
              end else begin
                state_q <= SCS_DS_IDLE;
              end
            end
            SCS_DS_OFFS: begin
              ptr_q    <= rx_q;
              sda_oe_q <= 1'b1;
            end
            SCS_DS_WDATA: begin
              ptr_q    <= ptr_q + 8'h01;
              sda_oe_q <= 1'b1;
            end
            SCS_DS_RDATA: ptr_q <= ptr_q + 8'h01;
            default: ;
          endcase
        end else if (bitcnt_q == 4'h9) begin
          bitcnt_q <= 4'h0;
          sda_oe_q <= 1'b0;
          case (state_q)
            SCS_DS_ADDR: begin
              if (rw_q) begin
                state_q  <= SCS_DS_RDATA;
                tx_q     <= rd_cur;
                sda_oe_q <= ~rd_cur[7];
              end else begin
                state_q <= SCS_DS_OFFS;
              end
            end
            SCS_DS_OFFS: state_q <= SCS_DS_WDATA;
            SCS_DS_RDATA: begin
              if (mack_q) begin
                tx_q     <= rd_cur;
                sda_oe_q <= ~rd_cur[7];
              end else begin
                state_q <= SCS_DS_IDLE;
              end
            end
            default: ;
          endcase
        end else if (state_q == SCS_DS_RDATA && bitcnt_q != 4'h0) begin
          tx_q     <= {tx_q[6:0], 1'b0};
          sda_oe_q <= ~tx_q[6];
        end
      end
    end
  end

  assign wr_en = power_down_n & scl_fall & (bitcnt_q == 4'h8) & (state_q == SCS_DS_WDATA);

  // Only presetn and the power-down pin reset the registers; stream loss or the sleep bit leave them alone.
  generate
    for (genvar i = 0; i < SCS_REG_COUNT; i++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_q[i] <= SCS_REG_RST[i];
        end else if (!power_down_n) begin
          regs_q[i] <= SCS_REG_RST[i];
        end else if (wr_en && ptr_q == 8'(i)) begin
          regs_q[i] <= rx_q;
        end
      end
    end
  endgenerate

  assign reg_ctrl = regs_q[0][SCS_CFG_REG_CTRL_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_freq_range_sel     <= 1'b0;
      output_sleep_state_sel <= 1'b0;
      sleep_mode             <= 1'b0;
      link_output_drive_en   <= 1'b0;
      swing_level_sel        <= 1'b0;
      internal_osc_freq_sel  <= 3'h0;
      bus_address_setting    <= SCS_ADDR_OPEN;
    end else begin
      if (reg_ctrl) begin
        low_freq_range_sel     <= regs_q[0][SCS_CFG_LOW_FREQ_BIT];
        output_sleep_state_sel <= regs_q[0][SCS_CFG_SLEEP_STATE_BIT];
        sleep_mode             <= regs_q[0][SCS_CFG_SLEEP_BIT];
        link_output_drive_en   <= regs_q[2][SCS_OUT_DRIVE_BIT];
        swing_level_sel        <= regs_q[2][SCS_OUT_SWING_BIT];
        internal_osc_freq_sel  <= regs_q[2][SCS_OSC_MSB:0];
      end else begin
        low_freq_range_sel     <= pin_low_freq_range_sel;
        output_sleep_state_sel <= pin_output_sleep_state_sel;
        sleep_mode             <= 1'b0;
        link_output_drive_en   <= pin_link_output_drive_en;
        swing_level_sel        <= pin_swing_level_sel;
        internal_osc_freq_sel  <= 3'h0;
      end
      bus_address_setting <= own_addr;
    end
  end
endmodule
`default_nettype wire

// file: hdl/scs_pkg.sv
`default_nettype none
package scs_pkg;

  // Device register offsets and values after reset.
  localparam logic [7:0] SCS_REG_LINK_CONFIG     = 8'h00;
  localparam logic [7:0] SCS_REG_BUS_ADDRESS_SEL = 8'h01;
  localparam logic [7:0] SCS_REG_OUTPUT_FEATURES = 8'h02;
  localparam int         SCS_REG_COUNT           = 3;
  localparam logic [2:0][7:0] SCS_REG_RST = {8'h00, 8'h70, 8'h00};

  // Field positions.
  localparam int SCS_CFG_LOW_FREQ_BIT    = 7;
  localparam int SCS_CFG_SLEEP_STATE_BIT = 6;
  localparam int SCS_CFG_SLEEP_BIT       = 1;
  localparam int SCS_CFG_REG_CTRL_BIT    = 0;
  localparam int SCS_ADDR_SRC_BIT        = 7;
  localparam int SCS_OUT_DRIVE_BIT       = 7;
  localparam int SCS_OUT_SWING_BIT       = 3;
  localparam int SCS_OSC_MSB             = 2;
  localparam int SCS_ADDR_W              = 7;

  // Bus addresses chosen by the strap resistor.
  localparam logic [6:0] SCS_ADDR_R0470 = 7'h71;
  localparam logic [6:0] SCS_ADDR_R2700 = 7'h72;
  localparam logic [6:0] SCS_ADDR_R8200 = 7'h73;
  localparam logic [6:0] SCS_ADDR_OPEN  = 7'h76;

  typedef enum logic [1:0] {
    SCS_STRAP_R0470,
    SCS_STRAP_R2700,
    SCS_STRAP_R8200,
    SCS_STRAP_OPEN
  } scs_strap_t;

  typedef enum logic [2:0] {
    SCS_DS_IDLE,
    SCS_DS_ADDR,
    SCS_DS_OFFS,
    SCS_DS_WDATA,
    SCS_DS_RDATA
  } scs_dev_state_t;

  typedef enum logic [1:0] {
    SCS_HS_IDLE,
    SCS_HS_START,
    SCS_HS_BIT,
    SCS_HS_STOP
  } scs_host_state_t;

  // Bus timing: one quarter of a 100 kHz bit period.
  localparam int SCS_CLK_NS      = 25;
  localparam int SCS_QUARTER_NS  = 2500;
  localparam int SCS_QUARTER_CYC = (SCS_QUARTER_NS + SCS_CLK_NS - 1) / SCS_CLK_NS;

  // Controller registers on APB.
  localparam logic [11:0] SCS_APB_CMD    = 12'h000;
  localparam logic [11:0] SCS_APB_TXDATA = 12'h004;
  localparam logic [11:0] SCS_APB_STATUS = 12'h008;
  localparam logic [11:0] SCS_APB_DIV    = 12'h00C;

  localparam int SCS_CMD_START_BIT  = 0;
  localparam int SCS_CMD_STOP_BIT   = 1;
  localparam int SCS_CMD_READ_BIT   = 2;
  localparam int SCS_CMD_NACK_BIT   = 3;
  localparam int SCS_CMD_NOBYTE_BIT = 4;
  localparam int SCS_CMD_W          = 5;

  localparam int SCS_STAT_BUSY_BIT = 0;
  localparam int SCS_STAT_ACK_BIT  = 1;
  localparam int SCS_STAT_RXD_LSB  = 8;

endpackage
`default_nettype wire

// file: hdl/scs_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scs_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups resolve released lines high; any enabled low driver wins.
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe,
    input  scl,
    input  sda
  );

  modport dev (
    output dev_sda_o,
    output dev_sda_oe,
    input  scl,
    input  sda
  );
endinterface
`default_nettype wire

// file: hdl/scs_host.sv
`timescale 1ns/1ps
`default_nettype none
module scs_host #(
  parameter logic [15:0] QUARTER_CYC = 16'(scs_pkg::SCS_QUARTER_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  scs_bus_if.host          bus,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import scs_pkg::*;

  scs_host_state_t     hs_q;
  logic [SCS_CMD_W-1:0] cmd_q;
  logic [7:0]          txd_q;
  logic [7:0]          rxd_q;
  logic [7:0]          sh_q;
  logic [15:0]         div_q;
  logic [15:0]         cnt_q;
  logic [1:0]          qtr_q;
  logic [3:0]          bit_q;
  logic                ack_q;
  logic                scl_oe_q;
  logic                sda_oe_q;
  logic                acc;
  logic                launch;
  logic                tick;
  logic                mapped;

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;

  assign mapped = (paddr == SCS_APB_CMD) || (paddr == SCS_APB_TXDATA) ||
                  (paddr == SCS_APB_STATUS) || (paddr == SCS_APB_DIV);
  assign acc    = psel & penable & pready;
  assign launch = acc & pwrite & (paddr == SCS_APB_CMD) & (hs_q == SCS_HS_IDLE);
  assign tick   = (hs_q != SCS_HS_IDLE) && (cnt_q >= div_q - 16'h0001);

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          SCS_APB_TXDATA: prdata <= {24'h00_0000, txd_q};
          SCS_APB_STATUS: prdata <= {16'h0000, rxd_q, 6'h00, ack_q, hs_q != SCS_HS_IDLE};
          SCS_APB_DIV:    prdata <= {16'h0000, div_q};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 8'h00;
      div_q <= QUARTER_CYC;
    end else if (acc && pwrite) begin
      if (paddr == SCS_APB_TXDATA) begin
        txd_q <= pwdata[7:0];
      end
      if (paddr == SCS_APB_DIV && pwdata[15:0] != 16'h0000) begin
        div_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (launch || tick) begin
      cnt_q <= 16'h0000;
    end else if (hs_q != SCS_HS_IDLE) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Each phase spans four quarter periods; actions fire on the quarter ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q     <= SCS_HS_IDLE;
      cmd_q    <= '0;
      sh_q     <= 8'h00;
      rxd_q    <= 8'h00;
      qtr_q    <= 2'h0;
      bit_q    <= 4'h0;
      ack_q    <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (hs_q)
        SCS_HS_IDLE: begin
          if (launch) begin
            cmd_q <= pwdata[SCS_CMD_W-1:0];
            sh_q  <= txd_q;
            qtr_q <= 2'h0;
            bit_q <= 4'h0;
            if (pwdata[SCS_CMD_START_BIT]) begin
              hs_q <= SCS_HS_START;
            end else if (!pwdata[SCS_CMD_NOBYTE_BIT]) begin
              hs_q <= SCS_HS_BIT;
            end else if (pwdata[SCS_CMD_STOP_BIT]) begin
              hs_q <= SCS_HS_STOP;
            end
          end
        end
        SCS_HS_START: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          case (qtr_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            default: begin
              scl_oe_q <= 1'b1;
              if (!cmd_q[SCS_CMD_NOBYTE_BIT]) begin
                hs_q <= SCS_HS_BIT;
              end else begin
                hs_q <= cmd_q[SCS_CMD_STOP_BIT] ? SCS_HS_STOP : SCS_HS_IDLE;
              end
            end
          endcase
        end
        SCS_HS_BIT: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          case (qtr_q)
            2'h0: begin
              if (bit_q < 4'h8) begin
                sda_oe_q <= ~cmd_q[SCS_CMD_READ_BIT] & ~sh_q[7];
              end else begin
                sda_oe_q <= cmd_q[SCS_CMD_READ_BIT] & ~cmd_q[SCS_CMD_NACK_BIT];
              end
            end
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (bit_q < 4'h8) begin
                sh_q <= {sh_q[6:0], bus.sda};
              end else begin
                ack_q <= ~bus.sda;
                if (cmd_q[SCS_CMD_READ_BIT]) begin
                  rxd_q <= sh_q;
                end
              end
            end
            default: begin
              scl_oe_q <= 1'b1;
              bit_q    <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                hs_q  <= cmd_q[SCS_CMD_STOP_BIT] ? SCS_HS_STOP : SCS_HS_IDLE;
              end
            end
          endcase
        end
        SCS_HS_STOP: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          case (qtr_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            default: hs_q <= SCS_HS_IDLE;
          endcase
        end
        default: hs_q <= SCS_HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: bench/scs_props.sv
`timescale 1ns/1ps
`default_nettype none
module scs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       scl_q;
  logic       sda_q;
  logic       frame_q;
  logic [3:0] bits_q;
  logic       start_c;
  logic       stop_c;

  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c  = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // The bit count saturates so that long frames never wrap into the address window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= 1'b0;
      bits_q  <= 4'h0;
    end else if (start_c) begin
      frame_q <= 1'b1;
      bits_q  <= 4'h0;
    end else begin
      if (stop_c) frame_q <= 1'b0;
      if (scl && !scl_q && bits_q != 4'hF) bits_q <= bits_q + 4'h1;
    end
  end

  a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives SDA high");
  a_host_open_drain: assert property (
    (host_sda_oe || host_scl_oe) |->
    !(host_sda_oe && host_sda_o) && !(host_scl_oe && host_scl_o))
    else $error("host drives a line high");
  a_dev_idle_quiet: assert property (!frame_q |-> !dev_sda_oe)
    else $error("device drives SDA outside a frame");
  a_addr_phase_quiet: assert property (frame_q && bits_q < 4'h8 |-> !dev_sda_oe)
    else $error("device drives SDA during the address byte");
  a_drive_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device starts driving while SCL is high");
  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device SDA changes while SCL is high");
  a_start_hold: assert property ($fell(sda) && scl |-> scl [*3])
    else $error("SCL falls too soon after a start");
  a_stop_idle: assert property ($rose(sda) && scl |-> (scl && sda) [*3])
    else $error("bus not idle after a stop");

  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_rep_start: cover property (start_c && frame_q);
  c_stop: cover property (stop_c);
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pdn_n, perr;
  logic        lf, oss, slp, drv, sw;
  logic [2:0]  osc;
  logic [6:0]  bas;
  logic [3:0]  pins;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [7:0]  rd;
  logic        ack;
  scs_strap_t  strap;
  int          n_fail, checks_done;

  scs_bus_if bus_i ();
  scs_host #(.QUARTER_CYC(16'h0004)) u_scs_host (.pclk(pclk), .presetn(presetn), .bus(bus_i),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  scs_device u_scs_device (.pclk(pclk), .presetn(presetn), .bus(bus_i), .power_down_n(pdn_n),
    .address_strap(strap), .pin_low_freq_range_sel(pins[3]),
    .pin_output_sleep_state_sel(pins[2]), .pin_link_output_drive_en(pins[1]),
    .pin_swing_level_sel(pins[0]), .low_freq_range_sel(lf), .output_sleep_state_sel(oss),
    .sleep_mode(slp), .link_output_drive_en(drv), .swing_level_sel(sw),
    .internal_osc_freq_sel(osc), .bus_address_setting(bas));
  scs_props u_scs_props (.pclk(pclk), .presetn(presetn), .host_scl_o(bus_i.host_scl_o),
    .host_scl_oe(bus_i.host_scl_oe), .host_sda_o(bus_i.host_sda_o),
    .host_sda_oe(bus_i.host_sda_oe), .dev_sda_o(bus_i.dev_sda_o),
    .dev_sda_oe(bus_i.dev_sda_oe), .scl(bus_i.scl), .sda(bus_i.sda));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [7:0] cfg();
    return {lf, oss, slp, drv, sw, osc};
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // The request is held until pready is sampled high, and read data is taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A slave that never answers is counted here; the run still reaches its verdict.
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input logic [4:0] c, input logic [7:0] tx, output logic [31:0] s);
    int k;
    apb(1'b1, SCS_APB_TXDATA, {24'h00_0000, tx}, s);
    apb(1'b1, SCS_APB_CMD, {27'h000_0000, c}, s);
    k = 0;
    do begin
      apb(1'b0, SCS_APB_STATUS, 32'h0000_0000, s);
      k++;
    end while (s[0] !== 1'b0 && k < 200);
    if (s[0] !== 1'b0) n_fail++;
  endtask

  task automatic dw(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
    op(5'h01, {a, 1'b0}, st);
    ack = st[1];
    op(5'h00, o, st);
    ack &= st[1];
    op(5'h02, d, st);
    ack &= st[1];
  endtask

  task automatic dr(input logic [6:0] a, input logic [7:0] o);
    op(5'h01, {a, 1'b0}, st);
    op(5'h00, o, st);
    op(5'h01, {a, 1'b1}, st);
    op(5'h0E, 8'hFF, st);
    rd = st[15:8];
  endtask

  task automatic t_reset_state();
    chk("idle lines", {bus_i.scl, bus_i.sda}, 2'b11);
    chk("pin cfg", cfg(), 8'h98);
    chk("strap addr", bas, SCS_ADDR_OPEN);
    dr(SCS_ADDR_OPEN, 8'h00);
    chk("reg0 rst", rd, 8'h00);
    dr(SCS_ADDR_OPEN, 8'h01);
    chk("reg1 rst", rd, 8'h70);
    // A bare start followed by a bare stop must leave both lines released.
    op(5'h11, 8'h00, st);
    chk("start only", {bus_i.scl, bus_i.sda}, 2'b00);
    op(5'h12, 8'h00, st);
    chk("stop only", {bus_i.scl, bus_i.sda}, 2'b11);
    apb(1'b1, SCS_APB_DIV, 32'h0000_0000, st);
    apb(1'b0, SCS_APB_DIV, 32'h0000_0000, st);
    chk("div", st, 32'h0000_0004);
    chk("div err", perr, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000, st);
    chk("unmapped err", perr, 1'b1);
    chk("unmapped data", st, 32'h0000_0000);
  endtask

  task automatic t_regs();
    dw(7'h70, 8'h00, 8'h01);
    chk("foreign ack", ack, 1'b0);
    dw(SCS_ADDR_OPEN, 8'h02, 8'h8D);
    chk("ack", ack, 1'b1);
    chk("pin mode", cfg(), 8'h98);
    dw(SCS_ADDR_OPEN, 8'h00, 8'hC3);
    chk("reg cfg", cfg(), 8'hFD);
    pins <= 4'b0100;
    repeat (4) @(posedge pclk);
    chk("pins ignored", cfg(), 8'hFD);
    pins <= 4'b1011;
    dr(SCS_ADDR_OPEN, 8'h00);
    chk("reg0 back", rd, 8'hC3);
    for (int c = 0; c < 8; c++) begin
      dw(SCS_ADDR_OPEN, 8'h02, 8'(c));
      chk("osc", cfg(), 8'hE0 | 8'(c));
    end
    dw(SCS_ADDR_OPEN, 8'h00, 8'h01);
    chk("wake", cfg(), 8'h07);
  endtask

  task automatic t_addr_src();
    dw(SCS_ADDR_OPEN, 8'h01, 8'hF3);
    chk("reg addr", bas, SCS_ADDR_R8200);
    dw(SCS_ADDR_OPEN, 8'h02, 8'h00);
    chk("old addr", ack, 1'b0);
    dr(SCS_ADDR_R8200, 8'h01);
    chk("reg1 back", rd, 8'hF3);
    dw(SCS_ADDR_R8200, 8'h01, 8'h73);
    chk("strap again", bas, SCS_ADDR_OPEN);
    dw(SCS_ADDR_OPEN, 8'h02, 8'h00);
    chk("strap ack", ack, 1'b1);
  endtask

  task automatic t_pdown();
    dw(SCS_ADDR_OPEN, 8'h00, 8'hC3);
    pdn_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pdn_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("pdown cfg", cfg(), 8'h98);
    dr(SCS_ADDR_OPEN, 8'h00);
    chk("pdown reg0", rd, 8'h00);
  endtask

  task automatic t_strap();
    logic [6:0] tbl [4];
    tbl = '{7'h71, 7'h72, 7'h73, 7'h76};
    for (int i = 0; i < 4; i++) begin
      strap <= scs_strap_t'(i);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("strap", bas, tbl[i]);
      dw(tbl[i], 8'h02, 8'h00);
      chk("strap ack", ack, 1'b1);
    end
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pdn_n = 1'b1;
    pins = 4'b1011;
    strap = SCS_STRAP_OPEN;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset_state();
    t_regs();
    t_addr_src();
    t_pdown();
    t_strap();
    results();
  end

  // The whole run needs some 14000 cycles; this bound leaves ample margin.
  initial begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
